// [rtl/demr_pkg.sv]
package demr_pkg;
  // ********************************************************
  // Bus geometry
  // ********************************************************
  localparam int ADDR_W = 22;
  localparam int DATA_W = 32;
  // ********************************************************
  // Register byte addresses
  // ********************************************************
  localparam logic [ADDR_W-1:0] OFF_COEF_D = 22'h30_215c;
  localparam logic [ADDR_W-1:0] OFF_COEF_E = 22'h30_2160;
  localparam logic [ADDR_W-1:0] OFF_COEF_F = 22'h30_2164;
  localparam logic [ADDR_W-1:0] OFF_SETUP = 22'h30_2168;
  localparam logic [ADDR_W-1:0] OFF_PT4_X = 22'h30_216c;
  localparam logic [ADDR_W-1:0] OFF_ACK = 22'h30_2170;
  localparam logic [ADDR_W-1:0] OFF_SELFTEST = 22'h30_2174;
  localparam logic [ADDR_W-1:0] OFF_TUNE = 22'h30_2184;
  localparam logic [ADDR_W-1:0] OFF_LINK = 22'h30_2188;
  localparam logic [ADDR_W-1:0] OFF_RAW_XY = 22'h30_218c;
  localparam logic [ADDR_W-1:0] OFF_RAW_Z = 22'h30_2190;
  localparam logic [ADDR_W-1:0] OFF_DATE0 = 22'h30_2560;
  localparam logic [ADDR_W-1:0] OFF_DATE1 = 22'h30_2564;
  localparam logic [ADDR_W-1:0] OFF_DATE2 = 22'h30_2568;
  localparam logic [ADDR_W-1:0] OFF_DATE3 = 22'h30_256c;
  localparam logic [ADDR_W-1:0] OFF_FREE = 22'h30_2574;
  localparam logic [ADDR_W-1:0] OFF_CMD = 22'h30_2578;
  localparam logic [ADDR_W-1:0] OFF_RELIEF = 22'h30_257c;
  localparam logic [ADDR_W-1:0] OFF_HOLD = 22'h30_25ec;
  localparam logic [ADDR_W-1:0] OFF_FLASH = 22'h30_25f0;
  localparam logic [ADDR_W-1:0] OFF_LATE = 22'h30_260c;
  localparam logic [ADDR_W-1:0] OFF_CEIL = 22'h30_2610;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 22'h30_2700;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 22'h30_2704;
  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [31:0] RST_COEF_D = 32'h0000_0000;
  localparam logic [31:0] RST_COEF_E = 32'h0001_0000;
  localparam logic [31:0] RST_COEF_F = 32'h0000_0000;
  localparam logic [15:0] RST_SETUP_RES = 16'h8381;
  localparam logic [15:0] RST_SETUP_CAP = 16'h0381;
  localparam logic [11:0] RST_FREE = 12'hffc;
  localparam logic RST_RELIEF = 1'h1;
  // ********************************************************
  // Fields and codes
  // ********************************************************
  localparam int LANES_MSB = 1;
  localparam int DUMMY_BIT = 2;
  localparam logic [11:0] CMD_WORD_BYTES = 12'h004;
  localparam logic [1:0] FLASH_INIT = 2'h0;
  localparam logic [1:0] FLASH_DETACHED = 2'h1;
  localparam logic [1:0] FLASH_BASIC = 2'h2;
  localparam logic [1:0] FLASH_FULL = 2'h3;
  localparam int IRQ_W = 3;
  localparam int IRQ_LATE = 0;
  localparam int IRQ_OVF = 1;
  localparam int IRQ_FLASH = 2;
endpackage

// [rtl/demr_regs.sv]
`timescale 1ns/100ps
// Operation
// [R1] Coefficients d, e, f are signed 16.16 words; e resets to one, others zero.
// [R2] Sixteen-bit touch setup register; reset value depends on sensing variant.
// [R3] Host writes four-bit touch handshake; device forwards it; resets to zero.
// [R4] One read/write bit maps memory self test into address space; resets zero.
// [R5] Link register bit 2 requests one extra dummy cycle on reads.
// [R6] Link register low bits select one, two or four data lines.
// [R7] Compatibility mode: two words give raw X/Y and Z1/Z2 conversions.
// [R8] Extended mode: same words give third and fourth point X/Y.
// [R9] Extended mode: separate register gives fifth point X.
// [R10] Twelve-bit free space count, resets to empty-buffer value.
// [R11] Each command port write appends a word and lowers free space; the code drops a write with under four bytes free and flags overflow.
// [R12] Frame rate relief enable bit, set at reset.
// [R13] Sound hold bit: zero plays, one pauses; resets to zero.
// [R14] Two-bit storage state: init, detached, basic, full; resets init.
// [R15] Twelve-bit line period ceiling; zero disables adaptive sync.
// [R16] Every register is word aligned; bits above its width read zero.
// [R17] Late line counter counts scan-out misses; unmapped reads zero.
// [R18] Fixed build date code over four words; eight-bit tuning register.
module demr_regs
  import demr_pkg::*;
#(
  parameter bit VARIANT_RES = 1'b1,
  parameter logic [127:0] BUILD_DATE = 128'h1234_5678_9abc_def0_0fed_cba9_8765_4321
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [DATA_W-1:0] readdata,
  output logic waitrequest,
  // Touch engine
  input wire logic touch_ext_mode,
  input wire logic [31:0] raw_xy,
  input wire logic [31:0] raw_z1z2,
  input wire logic [31:0] third_point_xy,
  input wire logic [31:0] fourth_point_xy,
  input wire logic [15:0] point4_x,
  output logic [31:0] coef_d,
  output logic [31:0] coef_e,
  output logic [31:0] coef_f,
  output logic [15:0] touch_setup,
  output logic [3:0] host_touch_handshake,
  // Memory and link control
  output logic selftest_map_enable,
  output logic [7:0] analogue_tuning,
  output logic [2:0] host_link_lanes,
  // Bulk command stream
  input wire logic cmd_drain,
  output logic [31:0] cmd_word,
  output logic cmd_valid,
  // Display, audio and storage
  input wire logic line_late,
  input wire logic flash_state_load,
  input wire logic [1:0] flash_state_in,
  output logic frame_rate_relief,
  output logic sound_hold,
  output logic [11:0] line_period_ceiling,
  output logic ahsync_enable,
  // Interrupt
  output logic irq
);
  // ********************************************************
  // Internal state
  // ********************************************************
  logic [11:0] bulk_cmd_free;
  logic [1:0] ext_storage_state;
  logic [31:0] late_line_count;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [31:0] rd_word;
  logic [IRQ_W-1:0] next_status;
  logic [11:0] next_free;

  // ********************************************************
  // Byte lane merge
  // ********************************************************
  function automatic logic [31:0] lane_merge(input logic [31:0] cur, input logic [31:0] nxt,
                                             input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (cur & ~m) | (nxt & m);
  endfunction

  // ********************************************************
  // Bus handshake
  // ********************************************************
  wire req = read | write;
  wire wr = write & ~waitrequest;
  wire rd = read & ~waitrequest;
  wire capture = read & waitrequest;
  wire [31:0] wmask = lane_merge(32'h0000_0000, 32'hffff_ffff, byteenable);
  wire [31:0] wd_m = writedata & wmask;
  wire [31:0] keep = ~wmask;

  // ********************************************************
  // Address decode
  // ********************************************************
  wire hit_d = address == OFF_COEF_D;
  wire hit_e = address == OFF_COEF_E;
  wire hit_f = address == OFF_COEF_F;
  wire hit_setup = address == OFF_SETUP;
  wire hit_pt4 = address == OFF_PT4_X;
  wire hit_ack = address == OFF_ACK;
  wire hit_self = address == OFF_SELFTEST;
  wire hit_tune = address == OFF_TUNE;
  wire hit_link = address == OFF_LINK;
  wire hit_rxy = address == OFF_RAW_XY;
  wire hit_rz = address == OFF_RAW_Z;
  wire hit_dt0 = address == OFF_DATE0;
  wire hit_dt1 = address == OFF_DATE1;
  wire hit_dt2 = address == OFF_DATE2;
  wire hit_dt3 = address == OFF_DATE3;
  wire hit_free = address == OFF_FREE;
  wire hit_cmd = address == OFF_CMD;
  wire hit_relief = address == OFF_RELIEF;
  wire hit_hold = address == OFF_HOLD;
  wire hit_flash = address == OFF_FLASH;
  wire hit_late = address == OFF_LATE;
  wire hit_ceil = address == OFF_CEIL;
  wire hit_stat = address == OFF_IRQ_STAT;
  wire hit_mask = address == OFF_IRQ_MASK;
  wire any_hit = hit_d | hit_e | hit_f | hit_setup | hit_pt4 | hit_ack | hit_self
               | hit_tune | hit_link | hit_rxy | hit_rz | hit_dt0 | hit_dt1
               | hit_dt2 | hit_dt3 | hit_free | hit_cmd | hit_relief | hit_hold
               | hit_flash | hit_late | hit_ceil | hit_stat | hit_mask;

  // ********************************************************
  // Read selection
  // ********************************************************
  wire [31:0] sel_xy = touch_ext_mode ? third_point_xy : raw_xy;
  wire [31:0] sel_z = touch_ext_mode ? fourth_point_xy : raw_z1z2;
  wire [15:0] sel_pt4 = touch_ext_mode ? point4_x : 16'h0000;

  assign rd_word = ({32{hit_d}} & coef_d)
                 | ({32{hit_e}} & coef_e)
                 | ({32{hit_f}} & coef_f)
                 | ({32{hit_setup}} & {16'h0000, touch_setup})
                 | ({32{hit_pt4}} & {16'h0000, sel_pt4})
                 | ({32{hit_ack}} & {28'h000_0000, host_touch_handshake})
                 | ({32{hit_self}} & {31'h0000_0000, selftest_map_enable})
                 | ({32{hit_tune}} & {24'h00_0000, analogue_tuning})
                 | ({32{hit_link}} & {29'h0000_0000, host_link_lanes})
                 | ({32{hit_rxy}} & sel_xy)
                 | ({32{hit_rz}} & sel_z)
                 | ({32{hit_dt0}} & BUILD_DATE[31:0])
                 | ({32{hit_dt1}} & BUILD_DATE[63:32])
                 | ({32{hit_dt2}} & BUILD_DATE[95:64])
                 | ({32{hit_dt3}} & BUILD_DATE[127:96])
                 | ({32{hit_free}} & {20'h0_0000, bulk_cmd_free})
                 | ({32{hit_relief}} & {31'h0000_0000, frame_rate_relief})
                 | ({32{hit_hold}} & {31'h0000_0000, sound_hold})
                 | ({32{hit_flash}} & {30'h0000_0000, ext_storage_state})
                 | ({32{hit_late}} & late_line_count)
                 | ({32{hit_ceil}} & {20'h0_0000, line_period_ceiling})
                 | ({32{hit_stat}} & {29'h0000_0000, irq_status})
                 | ({32{hit_mask}} & {29'h0000_0000, irq_mask}); // R7 R8 R9 R16 R17

  // ********************************************************
  // Command stream and events
  // ********************************************************
  wire cmd_room = bulk_cmd_free >= CMD_WORD_BYTES;
  wire cmd_push = wr & hit_cmd & cmd_room;
  wire cmd_ovf = wr & hit_cmd & ~cmd_room;
  wire cmd_back = cmd_drain & (bulk_cmd_free <= RST_FREE - CMD_WORD_BYTES);
  wire flash_chg = flash_state_load & (flash_state_in != ext_storage_state);
  wire [IRQ_W-1:0] events = {flash_chg, cmd_ovf, line_late};
  wire [IRQ_W-1:0] stat_clr = (rd & hit_stat) ? readdata[IRQ_W-1:0] : '0;

  always_comb begin
    next_free = bulk_cmd_free;
    if (wr & hit_free) begin
      next_free = (bulk_cmd_free & keep[11:0]) | wd_m[11:0];
    end else if (cmd_push & ~cmd_back) begin
      next_free = bulk_cmd_free - CMD_WORD_BYTES; // R11
    end else if (cmd_back & ~cmd_push) begin
      next_free = bulk_cmd_free + CMD_WORD_BYTES;
    end
  end

  // Bits seen by the read are cleared; a new event still wins
  assign next_status = (irq_status & ~stat_clr) | events;
  wire irq_pend = |(irq_status & irq_mask);

  // ********************************************************
  // Bus slave registers
  // ********************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else begin
      waitrequest <= ~(req & waitrequest);
      if (capture) begin
        readdata <= rd_word;
      end
    end
  end

  // ********************************************************
  // Touch registers
  // ********************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      coef_d <= RST_COEF_D; // R1
      coef_e <= RST_COEF_E; // R1
      coef_f <= RST_COEF_F; // R1
      touch_setup <= VARIANT_RES ? RST_SETUP_RES : RST_SETUP_CAP; // R2
      host_touch_handshake <= 4'h0; // R3
    end else begin
      if (wr & hit_d) begin
        coef_d <= lane_merge(coef_d, writedata, byteenable); // R1
      end
      if (wr & hit_e) begin
        coef_e <= lane_merge(coef_e, writedata, byteenable);
      end
      if (wr & hit_f) begin
        coef_f <= lane_merge(coef_f, writedata, byteenable);
      end
      if (wr & hit_setup) begin
        touch_setup <= (touch_setup & keep[15:0]) | wd_m[15:0]; // R2
      end
      if (wr & hit_ack) begin
        host_touch_handshake <= (host_touch_handshake & keep[3:0]) | wd_m[3:0]; // R3
      end
    end
  end

  // ********************************************************
  // Control registers
  // ********************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      selftest_map_enable <= 1'b0; // R4
      analogue_tuning <= 8'h00; // R18
      host_link_lanes <= 3'h0; // R5 R6
      frame_rate_relief <= RST_RELIEF; // R12
      sound_hold <= 1'b0; // R13
      line_period_ceiling <= 12'h000; // R15
      ahsync_enable <= 1'b0;
      irq_mask <= '0;
    end else begin
      if (wr & hit_self) begin
        selftest_map_enable <= (selftest_map_enable & keep[0]) | wd_m[0]; // R4
      end
      if (wr & hit_tune) begin
        analogue_tuning <= (analogue_tuning & keep[7:0]) | wd_m[7:0]; // R18
      end
      if (wr & hit_link) begin
        host_link_lanes <= (host_link_lanes & keep[2:0]) | wd_m[2:0]; // R5 R6
      end
      if (wr & hit_relief) begin
        frame_rate_relief <= (frame_rate_relief & keep[0]) | wd_m[0]; // R12
      end
      if (wr & hit_hold) begin
        sound_hold <= (sound_hold & keep[0]) | wd_m[0]; // R13
      end
      if (wr & hit_ceil) begin
        line_period_ceiling <= (line_period_ceiling & keep[11:0]) | wd_m[11:0];
      end
      ahsync_enable <= line_period_ceiling != 12'h000; // R15
      if (wr & hit_mask) begin
        irq_mask <= (irq_mask & keep[IRQ_W-1:0]) | wd_m[IRQ_W-1:0];
      end
    end
  end

  // ********************************************************
  // Status, counters and command stream
  // ********************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bulk_cmd_free <= RST_FREE; // R10
      cmd_word <= 32'h0000_0000;
      cmd_valid <= 1'b0;
      ext_storage_state <= FLASH_INIT; // R14
      late_line_count <= 32'h0000_0000;
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      bulk_cmd_free <= next_free; // R10
      cmd_valid <= cmd_push; // R11
      if (cmd_push) begin
        cmd_word <= writedata;
      end
      if (flash_state_load) begin
        ext_storage_state <= flash_state_in; // R14
      end else if (wr & hit_flash) begin
        ext_storage_state <= (ext_storage_state & keep[1:0]) | wd_m[1:0];
      end
      if (line_late) begin
        late_line_count <= late_line_count + 32'h0000_0001; // R17
      end
      irq_status <= next_status;
      irq <= irq_pend;
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  chk_wait_release: assert property ( // R16
    req && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest did not pulse low once");
  chk_coef_write: assert property ( // R1
    wr && hit_e && byteenable == 4'hf |=> coef_e == $past(writedata))
    else $error("coefficient write lost");
  chk_ack_width: assert property ( // R3
    rd && hit_ack |-> readdata[31:4] == 28'h000_0000)
    else $error("handshake upper bits not zero");
  chk_link_dummy: assert property ( // R5
    wr && hit_link && byteenable[0] |=> host_link_lanes[DUMMY_BIT] == $past(writedata[2]))
    else $error("dummy cycle bit not stored");
  chk_link_lanes: assert property ( // R6
    wr && hit_link && byteenable[0]
    |=> host_link_lanes[LANES_MSB:0] == $past(writedata[1:0]))
    else $error("lane select not stored");
  chk_raw_compat: assert property ( // R7
    rd && hit_rz && !$past(touch_ext_mode) |-> readdata == $past(raw_z1z2))
    else $error("raw pressure word wrong");
  chk_point_ext: assert property ( // R8
    rd && hit_rxy && $past(touch_ext_mode) |-> readdata == $past(third_point_xy))
    else $error("third point word wrong");
  chk_fifth_x: assert property ( // R9
    rd && hit_pt4 && $past(touch_ext_mode) |-> readdata == {16'h0000, $past(point4_x)})
    else $error("fifth point x wrong");
  chk_free_drop: assert property ( // R11
    cmd_push && !cmd_drain |=> bulk_cmd_free == $past(bulk_cmd_free) - CMD_WORD_BYTES
    && cmd_valid && cmd_word == $past(writedata))
    else $error("command push not accounted");
  chk_free_bound: assert property ( // R10
    bulk_cmd_free <= RST_FREE && !(wr && hit_free) |=> bulk_cmd_free <= RST_FREE)
    else $error("free space above empty value");
  chk_flash_load: assert property ( // R14
    flash_state_load |=> ext_storage_state == $past(flash_state_in))
    else $error("storage state not loaded");
  chk_ahsync_gate: assert property ( // R15
    line_period_ceiling == 12'h000 [*2] |-> !ahsync_enable)
    else $error("adaptive sync on with zero ceiling");
  chk_late_count: assert property ( // R17
    line_late |=> late_line_count == $past(late_line_count) + 32'h0000_0001)
    else $error("late line not counted");
  chk_unmapped_zero: assert property ( // R17
    rd && !any_hit |-> readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_event_sticky: assert property (
    line_late |=> irq_status[IRQ_LATE])
    else $error("late event not latched");
  chk_ovf_sticky: assert property ( // R11
    cmd_ovf |=> irq_status[IRQ_OVF])
    else $error("overflow event not latched");
  chk_flash_sticky: assert property ( // R14
    flash_chg |=> irq_status[IRQ_FLASH])
    else $error("storage change not latched");
  chk_stat_clear: assert property (
    rd && hit_stat && readdata[IRQ_LATE] && !line_late |=> !irq_status[IRQ_LATE])
    else $error("status bit not cleared by read");
  chk_irq_level: assert property (
    irq == $past(irq_pend))
    else $error("interrupt level wrong");
  chk_read_hold: assert property (
    !capture |=> $stable(readdata))
    else $error("read data changed without capture");
  chk_cmd_pulse: assert property ( // R11
    cmd_valid |=> !cmd_valid)
    else $error("command valid longer than one cycle");
endmodule

// [verif/demr_host.sv]
`timescale 1ns/100ps
module demr_host
  import demr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Avalon-MM master
  output logic [ADDR_W-1:0] address,
  output logic read,
  output logic write,
  output logic [DATA_W-1:0] writedata,
  output logic [3:0] byteenable,
  input wire logic [DATA_W-1:0] readdata,
  input wire logic waitrequest
);
  int n_to;
  initial begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    byteenable = 4'hf;
    n_to = 0;
  end
  // ****
  // One transfer, held until waitrequest low
  // ****
  task automatic xfer(input bit rd, input logic [3:0] m, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk);
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= d;
    byteenable <= m;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (i == 50) n_to++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule

// [verif/display_engine_misc_registers_tb.sv]
`timescale 1ns/100ps
module display_engine_misc_registers_tb
  import demr_pkg::*;
;
  localparam logic [127:0] DATE = 128'h0102_0304_0506_0708_090a_0b0c_0d0e_0f10;
  logic clk, rstn, rd_s, wr_s, waitrequest, ext, drain, late, fload, cmd_valid, irq;
  logic [ADDR_W-1:0] address;
  logic [31:0] wdata, rdata, raw_xy, raw_z, pt2, pt3, coef_d, coef_e, coef_f, cmd_word;
  logic [31:0] last_cmd = '0;
  logic [15:0] pt4, setup;
  logic [3:0] be, ack;
  logic [1:0] fin;
  logic [2:0] lanes;
  logic [7:0] tune;
  logic [11:0] ceil;
  logic sel, relief, hold, ahs;
  int n_fail, num_checks;
  int n_cmd = 0;
  // ****
  // Design and host
  // ****
  demr_regs #(.VARIANT_RES(1'b1), .BUILD_DATE(DATE)) i_demr_regs (
    .clk(clk), .rstn(rstn), .address(address), .read(rd_s), .write(wr_s),
    .writedata(wdata), .byteenable(be), .readdata(rdata), .waitrequest(waitrequest),
    .touch_ext_mode(ext), .raw_xy(raw_xy), .raw_z1z2(raw_z), .third_point_xy(pt2),
    .fourth_point_xy(pt3), .point4_x(pt4), .coef_d(coef_d), .coef_e(coef_e),
    .coef_f(coef_f), .touch_setup(setup), .host_touch_handshake(ack),
    .selftest_map_enable(sel), .analogue_tuning(tune), .host_link_lanes(lanes),
    .cmd_drain(drain), .cmd_word(cmd_word), .cmd_valid(cmd_valid), .line_late(late),
    .flash_state_load(fload), .flash_state_in(fin), .frame_rate_relief(relief),
    .sound_hold(hold), .line_period_ceiling(ceil), .ahsync_enable(ahs), .irq(irq));
  demr_host i_demr_host (
    .clk(clk), .address(address), .read(rd_s), .write(wr_s), .writedata(wdata),
    .byteenable(be), .readdata(rdata), .waitrequest(waitrequest));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) begin
      n_cmd <= n_cmd + 1;
      last_cmd <= cmd_word;
    end
  end
  // ****
  // Checking and bus tasks
  // ****
  task automatic summarize;
    n_fail += i_demr_host.n_to;
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input bit r, input logic [3:0] m, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    i_demr_host.xfer(r, m, a, d, q);
    if (i_demr_host.n_to != 0) summarize();
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b1, 4'hf, a, '0, q);
    chk(q, exp);
  endtask
  task automatic wrm(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] m);
    logic [31:0] q;
    bus(1'b0, m, a, d, q);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    wrm(a, d, 4'hf);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    n_fail = 0;
    num_checks = 0;
    rstn = 1'b0;
    {ext, drain, late, fload, fin} = '0;
    raw_xy = 32'h1234_5678;
    raw_z = 32'h0abc_0def;
    pt2 = 32'h0111_0222;
    pt3 = 32'h0333_0444;
    pt4 = 16'hbeef;
    tick(4);
    rstn <= 1'b1;
    rd(OFF_COEF_D, 32'h0000_0000);
    rd(OFF_COEF_E, 32'h0001_0000);
    rd(OFF_COEF_F, 32'h0000_0000);
    rd(OFF_SETUP, 32'h0000_8381);
    rd(OFF_ACK, 32'h0000_0000);
    rd(OFF_SELFTEST, 32'h0000_0000);
    rd(OFF_TUNE, 32'h0000_0000);
    rd(OFF_LINK, 32'h0000_0000);
    rd(OFF_FREE, 32'h0000_0ffc);
    rd(OFF_RELIEF, 32'h0000_0001);
    rd(OFF_HOLD, 32'h0000_0000);
    rd(OFF_FLASH, 32'h0000_0000);
    rd(OFF_CEIL, 32'h0000_0000);
    rd(OFF_LATE, 32'h0000_0000);
    // Registers masked to their width
    wr(OFF_COEF_F, 32'h8000_0001);
    rd(OFF_COEF_F, 32'h8000_0001);
    chk(coef_f, 32'h8000_0001);
    wr(OFF_COEF_D, 32'hfffe_8000);
    rd(OFF_COEF_D, 32'hfffe_8000);
    chk(coef_d, 32'hfffe_8000);
    wr(OFF_COEF_E, 32'hffff_0000);
    wrm(OFF_COEF_E, 32'h1122_3344, 4'h5);
    rd(OFF_COEF_E, 32'hff22_0044);
    chk(coef_e, 32'hff22_0044);
    wr(OFF_SETUP, 32'hffff_ffff);
    rd(OFF_SETUP, 32'h0000_ffff);
    chk({16'h0000, setup}, 32'h0000_ffff);
    wr(OFF_ACK, 32'hffff_ffff);
    rd(OFF_ACK, 32'h0000_000f);
    chk({28'h0, ack}, 32'h0000_000f);
    wr(OFF_SELFTEST, 32'hffff_ffff);
    rd(OFF_SELFTEST, 32'h0000_0001);
    chk({31'h0, sel}, 32'h0000_0001);
    wr(OFF_TUNE, 32'hffff_ffff);
    rd(OFF_TUNE, 32'h0000_00ff);
    chk({24'h00_0000, tune}, 32'h0000_00ff);
    for (int k = 0; k < 4; k++) begin
      wr(OFF_LINK, 32'(k) | 32'h0000_0004);
      rd(OFF_LINK, 32'(k) | 32'h0000_0004);
      chk({29'h0, lanes}, 32'(k) | 32'h0000_0004);
    end
    wr(OFF_RELIEF, 32'hffff_fffe);
    rd(OFF_RELIEF, 32'h0000_0000);
    chk({31'h0, relief}, 32'h0000_0000);
    wr(OFF_HOLD, 32'hffff_ffff);
    rd(OFF_HOLD, 32'h0000_0001);
    chk({31'h0, hold}, 32'h0000_0001);
    wr(OFF_CEIL, 32'hffff_ffff);
    rd(OFF_CEIL, 32'h0000_0fff);
    chk({20'h0_0000, ceil}, 32'h0000_0fff);
    chk({31'h0, ahs}, 32'h0000_0001);
    wr(OFF_CEIL, 32'h0000_0000);
    tick(2);
    chk({31'h0, ahs}, 32'h0000_0000);
    // Reserved and read-only places
    wr(22'h30_2178, 32'hffff_ffff);
    rd(22'h30_2178, 32'h0000_0000);
    wr(OFF_RAW_XY, 32'hffff_ffff);
    rd(OFF_RAW_XY, 32'h1234_5678);
    rd(OFF_RAW_Z, 32'h0abc_0def);
    rd(OFF_PT4_X, 32'h0000_0000);
    rd(OFF_CMD, 32'h0000_0000);
    ext <= 1'b1;
    rd(OFF_RAW_XY, 32'h0111_0222);
    rd(OFF_RAW_Z, 32'h0333_0444);
    rd(OFF_PT4_X, 32'h0000_beef);
    for (int k = 0; k < 4; k++) begin
      rd(OFF_DATE0 + 22'(4 * k), DATE[32 * k +: 32]);
    end
    // Bulk command push and drain
    wr(OFF_CMD, 32'hcafe_0001);
    tick(2);
    chk(32'(n_cmd), 32'h0000_0001);
    chk(last_cmd, 32'hcafe_0001);
    rd(OFF_FREE, 32'h0000_0ff8);
    drain <= 1'b1;
    tick(1);
    drain <= 1'b0;
    rd(OFF_FREE, 32'h0000_0ffc);
    drain <= 1'b1;
    tick(1);
    drain <= 1'b0;
    rd(OFF_FREE, 32'h0000_0ffc);
    // Late lines, masked then unmasked
    late <= 1'b1;
    tick(1);
    late <= 1'b0;
    tick(3);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(OFF_LATE, 32'h0000_0001);
    rd(OFF_IRQ_STAT, 32'h0000_0001);
    rd(OFF_IRQ_STAT, 32'h0000_0000);
    wr(OFF_IRQ_MASK, 32'h0000_0007);
    rd(OFF_IRQ_MASK, 32'h0000_0007);
    late <= 1'b1;
    tick(1);
    late <= 1'b0;
    tick(3);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(OFF_IRQ_STAT, 32'h0000_0001);
    tick(2);
    chk({31'h0, irq}, 32'h0000_0000);
    rd(OFF_LATE, 32'h0000_0002);
    // Push into a nearly full buffer
    wr(OFF_FREE, 32'h0000_0004);
    wr(OFF_CMD, 32'h0000_00a1);
    wr(OFF_CMD, 32'h0000_00a2);
    tick(2);
    chk(32'(n_cmd), 32'h0000_0002);
    chk(last_cmd, 32'h0000_00a1);
    rd(OFF_FREE, 32'h0000_0000);
    rd(OFF_IRQ_STAT, 32'h0000_0002);
    // Storage state codes loaded by hardware
    wr(OFF_FLASH, 32'h0000_0002);
    rd(OFF_FLASH, 32'h0000_0002);
    for (int k = 1; k < 5; k++) begin
      fin <= 2'(k);
      fload <= 1'b1;
      tick(1);
      fload <= 1'b0;
      rd(OFF_FLASH, 32'(k % 4));
      rd(OFF_IRQ_STAT, 32'h0000_0004);
    end
    // Reset in mid-run restores the registers
    rstn <= 1'b0;
    tick(2);
    rstn <= 1'b1;
    rd(OFF_COEF_E, 32'h0001_0000);
    rd(OFF_FLASH, 32'h0000_0000);
    rd(OFF_FREE, 32'h0000_0ffc);
    rd(OFF_LATE, 32'h0000_0000);
    chk({31'h0, relief}, 32'h0000_0001);
    summarize();
  end
endmodule
